// *** design/sspc_ctrl.sv ***
`timescale 1ns/1ps
module sspc_ctrl (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // configuration
  input wire logic enable,
  input wire logic master_mode,
  input wire logic loopback,
  input wire logic [1:0] frame_format,
  input wire logic [3:0] data_size,
  input wire logic idle_clock_polarity,
  input wire logic capture_phase_select,
  input wire logic [7:0] prescale_divisor,
  input wire logic [7:0] clock_rate_field,
  input wire logic [3:0] interrupt_mask_register,
  input wire logic clear_timeout,
  input wire logic clear_overrun,
  // transmit words from the cpu
  input wire logic wr_valid,
  input wire logic [15:0] wr_data,
  output logic wr_ready,
  // receive words to the cpu
  output logic rd_valid,
  output logic [15:0] rd_data,
  input wire logic rd_ready,
  // status
  output logic [3:0] raw_interrupt_status,
  output logic [3:0] masked_interrupt_status,
  output logic irq,
  output logic busy,
  // serial pins
  input wire logic serial_bit_clock_in,
  output logic serial_bit_clock_out,
  output logic serial_bit_clock_oe,
  input wire logic frame_select_line_in,
  output logic frame_select_line_out,
  output logic frame_select_line_oe,
  input wire logic serial_in_line,
  output logic serial_out_line,
  output logic serial_out_oe
);

  // buffer occupancy update
  function automatic logic [3:0] cnt_next(input logic [3:0] c, input logic inc, input logic dec);
    return 4'(c + {3'h0, inc} - {3'h0, dec});
  endfunction

  sspc_pkg::sspc_state_e state;
  logic [15:0] tx_mem [sspc_pkg::DEPTH];
  logic [15:0] rx_mem [sspc_pkg::DEPTH];
  logic [2:0] tx_wp, tx_rp, rx_wp, rx_rp;
  logic [3:0] tx_cnt, rx_cnt;
  logic [15:0] ob1;
  logic [1:0] ob_cnt;
  logic [7:0] pre_cnt, rate_cnt;
  logic [15:0] shreg, rxsh;
  logic [4:0] bidx;
  logic [1:0] tail_cnt;
  logic s_prev, f_prev, rto, rovr;
  logic [5:0] to_cnt;

  // format decode
  wire [3:0] size = (data_size < sspc_pkg::MIN_SIZE) ? sspc_pkg::MIN_SIZE : data_size;
  wire pulse = frame_format == sspc_pkg::FMT_PULSE;
  wire cmd = (frame_format == sspc_pkg::FMT_CMD) & master_mode;
  wire spi = ~pulse & ~cmd;
  wire cpol = (frame_format == sspc_pkg::FMT_SPI) & idle_clock_polarity;
  wire cpha = pulse | ((frame_format == sspc_pkg::FMT_SPI) & capture_phase_select);
  wire [4:0] rx_start = cmd ? sspc_pkg::CMD_RX_START : pulse ? sspc_pkg::PULSE_RX_START : 5'h00;
  wire [4:0] last_idx = rx_start + {1'b0, size};

  // bit clock divider and edge events
  wire idle = state == sspc_pkg::ST_IDLE;
  wire pre_done = (pre_cnt + 8'h01) >= {1'b0, prescale_divisor[7:1]};
  wire half_tick = pre_done & (rate_cnt == clock_rate_field);
  wire m_toggle = master_mode & half_tick & ((state == sspc_pkg::ST_RUN) | (serial_bit_clock_out != cpol));
  wire s_edge = ~master_mode & (serial_bit_clock_in != s_prev);
  wire clk_was = master_mode ? serial_bit_clock_out : s_prev;
  wire edge_ev = (state == sspc_pkg::ST_RUN) & (master_mode ? half_tick : s_edge);
  wire lead = edge_ev & (clk_was == cpol);
  wire trail = edge_ev & (clk_was != cpol);
  wire samp = cpha ? trail : lead;
  wire shft = (cpha ? lead : trail) & ~(pulse & (bidx == 5'h00));
  wire rx_bit = loopback ? serial_out_line : serial_in_line;
  wire done = samp & (bidx == last_idx);
  wire [15:0] rx_word = {rxsh[14:0], rx_bit} & (16'hffff >> (4'hf - size));

  // frame start, chaining and word load
  wire m_start = master_mode & enable & idle & (tx_cnt != 4'h0);
  wire s_fss = pulse ? (frame_select_line_in & ~f_prev) : (~frame_select_line_in & f_prev);
  wire s_start = ~master_mode & enable & idle & s_fss;
  wire tail_end = (state == sspc_pkg::ST_TAIL) & half_tick & (tail_cnt == 2'h1);
  wire m_chain = tail_end & spi & cpha & (tx_cnt != 4'h0);
  wire s_chain = ~master_mode & done & spi & cpha & ~frame_select_line_in;
  wire s_abort = ~master_mode & (state == sspc_pkg::ST_RUN) & spi & frame_select_line_in;
  wire ld = m_start | s_start | m_chain | s_chain;
  wire [15:0] ld_word = tx_mem[tx_rp];
  wire [15:0] ld_al = cmd ? {ld_word[7:0], 8'h00} : 16'(ld_word << (4'hf - size));
  wire ld_msb = ld_al[15];

  // buffer handshakes
  wire tx_push = wr_valid & wr_ready;
  wire tx_pop = ld & (tx_cnt != 4'h0);
  wire rx_push = done & (rx_cnt != sspc_pkg::FULL_CNT);
  wire ovr_evt = done & (rx_cnt == sspc_pkg::FULL_CNT);
  wire take = rd_valid & rd_ready;
  wire rx_pop = (rx_cnt != 4'h0) & ((ob_cnt != 2'h2) | take);
  wire [1:0] ob_wi = ob_cnt - 2'(take);
  wire rx_has = (rx_cnt != 4'h0) | rd_valid;
  wire to_evt = rx_has & ~edge_ev & (to_cnt == sspc_pkg::TIMEOUT_CYC - 6'h01);

  // ports and status
  assign wr_ready = tx_cnt != sspc_pkg::FULL_CNT;
  assign rd_valid = ob_cnt != 2'h0;
  assign busy = ~idle | (tx_cnt != 4'h0);
  assign raw_interrupt_status = {rovr, rto, rx_cnt >= sspc_pkg::RX_SVC_LVL, tx_cnt <= sspc_pkg::TX_SVC_LVL};
  assign masked_interrupt_status = raw_interrupt_status & interrupt_mask_register;
  assign irq = |masked_interrupt_status;
  assign serial_bit_clock_oe = master_mode & enable;
  assign frame_select_line_oe = master_mode & enable;
  assign frame_select_line_out = pulse ? ((state == sspc_pkg::ST_RUN) & (bidx == 5'h00)) : idle;
  assign serial_out_oe = ~idle;

  // transmit buffer; slots keep old words for empty slave reads
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < sspc_pkg::DEPTH; i++) tx_mem[i] <= sspc_pkg::WORD_RST;
      tx_wp <= 3'h0;
      tx_rp <= 3'h0;
      tx_cnt <= 4'h0;
    end else begin
      if (tx_push) tx_mem[tx_wp] <= wr_data;
      tx_wp <= tx_wp + 3'(tx_push);
      tx_rp <= tx_rp + 3'(tx_pop);
      tx_cnt <= cnt_next(tx_cnt, tx_push, tx_pop);
    end
  end

  // receive buffer storage
  always_ff @(posedge clock) begin
    if (rx_push) rx_mem[rx_wp] <= rx_word;
  end

  // receive pointers and two-entry output stage
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rx_wp <= 3'h0;
      rx_rp <= 3'h0;
      rx_cnt <= 4'h0;
      ob_cnt <= 2'h0;
      rd_data <= sspc_pkg::WORD_RST;
      ob1 <= sspc_pkg::WORD_RST;
    end else begin
      rx_wp <= rx_wp + 3'(rx_push);
      rx_rp <= rx_rp + 3'(rx_pop);
      rx_cnt <= cnt_next(rx_cnt, rx_push, rx_pop);
      ob_cnt <= 2'(cnt_next({2'h0, ob_cnt}, rx_pop, take));
      if (take) rd_data <= ob1;
      if (rx_pop && ob_wi == 2'h0) rd_data <= rx_mem[rx_rp];
      if (rx_pop && ob_wi == 2'h1) ob1 <= rx_mem[rx_rp];
    end
  end

  // divider counters and master bit clock
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pre_cnt <= 8'h00;
      rate_cnt <= 8'h00;
      serial_bit_clock_out <= 1'b0;
      s_prev <= 1'b0;
      f_prev <= 1'b1;
    end else begin
      s_prev <= serial_bit_clock_in;
      f_prev <= frame_select_line_in;
      pre_cnt <= (idle | pre_done) ? 8'h00 : pre_cnt + 8'h01;
      rate_cnt <= (idle | half_tick) ? 8'h00 : rate_cnt + 8'(pre_done);
      if (idle) serial_bit_clock_out <= cpol;
      else if (m_toggle) serial_bit_clock_out <= ~serial_bit_clock_out;
    end
  end

  // frame sequencer
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state <= sspc_pkg::ST_IDLE;
      tail_cnt <= 2'h0;
      bidx <= 5'h00;
    end else begin
      if (!enable || s_abort) state <= sspc_pkg::ST_IDLE;
      else if (ld) state <= sspc_pkg::ST_RUN;
      else if (done) state <= master_mode ? sspc_pkg::ST_TAIL : sspc_pkg::ST_IDLE;
      else if (tail_end) state <= sspc_pkg::ST_IDLE;
      tail_cnt <= (state != sspc_pkg::ST_TAIL) ? 2'h0 : tail_cnt + 2'(half_tick);
      if (ld) bidx <= 5'h00;
      else if (samp) bidx <= bidx + 5'h01;
    end
  end

  // transmit and receive shifters
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      shreg <= sspc_pkg::WORD_RST;
      rxsh <= sspc_pkg::WORD_RST;
      serial_out_line <= 1'b0;
    end else begin
      if (ld) begin
        shreg <= cpha ? ld_al : {ld_al[14:0], 1'b0};
        serial_out_line <= cpha ? 1'b0 : ld_msb;
      end else if (shft) begin
        shreg <= {shreg[14:0], 1'b0};
        serial_out_line <= shreg[15];
      end else if (idle) begin
        serial_out_line <= 1'b0;
      end
      if (ld) rxsh <= sspc_pkg::WORD_RST;
      else if (samp && bidx >= rx_start) rxsh <= {rxsh[14:0], rx_bit};
    end
  end

  // timeout counter and sticky flags, set wins over clear
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      to_cnt <= 6'h00;
      rto <= 1'b0;
      rovr <= 1'b0;
    end else begin
      to_cnt <= (~rx_has | edge_ev | to_evt) ? 6'h00 : to_cnt + 6'h01;
      rto <= to_evt | (rto & ~clear_timeout);
      rovr <= ovr_evt | (rovr & ~clear_overrun);
    end
  end

  // checks
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence s_idle2;
    idle [*2];
  endsequence
  sequence s_pulse_go;
    m_start && pulse;
  endsequence

  property p_idle_clk;
    s_idle2 |-> serial_bit_clock_out == $past(cpol);
  endproperty
  a_idle_clk: assert property (p_idle_clk) else $error("bit clock left idle level");

  property p_size;
    rx_push |-> (rx_word & ~(16'hffff >> (4'hf - size))) == 16'h0000;
  endproperty
  a_size: assert property (p_size) else $error("received word wider than frame");

  property p_depth;
    tx_cnt <= sspc_pkg::FULL_CNT && rx_cnt <= sspc_pkg::FULL_CNT && (tx_cnt == sspc_pkg::FULL_CNT) == !wr_ready;
  endproperty
  a_depth: assert property (p_depth) else $error("buffer depth broken");

  property p_slave_pins;
    !master_mode |-> !serial_bit_clock_oe && !frame_select_line_oe;
  endproperty
  a_slave_pins: assert property (p_slave_pins) else $error("slave drives clock or frame");

  property p_push;
    tx_push && !tx_pop |=> tx_cnt == $past(tx_cnt) + 4'h1;
  endproperty
  a_push: assert property (p_push) else $error("write not stored");

  property p_empty_hold;
    ld && tx_cnt == 4'h0 |=> tx_rp == $past(tx_rp);
  endproperty
  a_empty_hold: assert property (p_empty_hold) else $error("empty load moved pointer");

  property p_pulse;
    s_pulse_go |=> frame_select_line_out && bidx == 5'h00 ##1 frame_select_line_out || $past(samp);
  endproperty
  a_pulse: assert property (p_pulse) else $error("frame pulse missing");

  property p_frame_low;
    master_mode && !pulse && !idle |-> !frame_select_line_out;
  endproperty
  a_frame_low: assert property (p_frame_low) else $error("frame line high in transfer");

  property p_release;
    tail_end && !m_chain && !pulse && enable |=> frame_select_line_out && idle;
  endproperty
  a_release: assert property (p_release) else $error("frame line not released");

  property p_ovr;
    ovr_evt |=> raw_interrupt_status[sspc_pkg::IRQ_OVR] && rx_cnt == $past(rx_cnt) - 4'($past(rx_pop));
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun not flagged");

  property p_irq;
    raw_interrupt_status[sspc_pkg::IRQ_TO] && interrupt_mask_register[sspc_pkg::IRQ_TO] |-> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("enabled source not on request");

  property p_timeout;
    $rose(rto) |-> $past(rx_has) && $past(to_cnt) == sspc_pkg::TIMEOUT_CYC - 6'h01;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout without idle period");

  property p_msb;
    ld && !cpha |=> serial_out_line == $past(ld_msb);
  endproperty
  a_msb: assert property (p_msb) else $error("first bit not msb");

  // command bits never reach the receive shifter
  property p_cmd_ignore;
    samp && !ld && bidx < rx_start |=> rxsh == $past(rxsh);
  endproperty
  a_cmd_ignore: assert property (p_cmd_ignore) else $error("input taken during command");

  // phase one chaining keeps the frame line low
  property p_chain_low;
    m_chain && enable |=> !frame_select_line_out && !idle;
  endproperty
  a_chain_low: assert property (p_chain_low) else $error("frame line rose between chained words");

  // master ends every frame through the tail state
  property p_tail;
    done && master_mode && enable |=> state == sspc_pkg::ST_TAIL;
  endproperty
  a_tail: assert property (p_tail) else $error("frame end skipped tail");

  // data pin is driven for the whole transfer
  property p_out_oe;
    !idle |-> serial_out_oe;
  endproperty
  a_out_oe: assert property (p_out_oe) else $error("data pin released in transfer");

  // pulse format shifts only on leading edges
  property p_pulse_shift;
    pulse && shft |-> lead;
  endproperty
  a_pulse_shift: assert property (p_pulse_shift) else $error("pulse data changed on falling edge");

endmodule

// *** design/sspc_pkg.sv ***
package sspc_pkg;

  localparam int DEPTH = 8;
  localparam logic [3:0] FULL_CNT = 4'h8;
  localparam logic [3:0] TX_SVC_LVL = 4'h4;
  localparam logic [3:0] RX_SVC_LVL = 4'h4;
  localparam logic [1:0] FMT_SPI = 2'h0;
  localparam logic [1:0] FMT_PULSE = 2'h1;
  localparam logic [1:0] FMT_CMD = 2'h2;
  localparam logic [3:0] MIN_SIZE = 4'h3;
  localparam logic [4:0] CMD_RX_START = 5'h09;
  localparam logic [4:0] PULSE_RX_START = 5'h01;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int TIMEOUT_NS = 3200;
  localparam logic [5:0] TIMEOUT_CYC = 6'((TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int IRQ_TO = 2;
  localparam int IRQ_OVR = 3;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_TAIL} sspc_state_e;
endpackage

// *** tb/sspc_ctrl_tb.sv ***
`timescale 1ns/1ps
module sspc_ctrl_tb;
  logic clock, rstn, enable, master_mode, loopback, idle_clock_polarity, capture_phase_select;
  logic [1:0] frame_format;
  logic [3:0] data_size, interrupt_mask_register, raw_interrupt_status, masked_interrupt_status;
  logic [7:0] prescale_divisor, clock_rate_field;
  logic clear_timeout, clear_overrun, wr_valid, wr_ready, rd_valid, rd_ready, irq, busy;
  logic [15:0] wr_data, rd_data, peer_reply, peer_got;
  logic sclk, sclk_oe, fss, fss_oe, miso, mosi, mosi_oe;
  int err_total, comparisons;

  sspc_ctrl DUT (.clock(clock), .rstn(rstn), .enable(enable), .master_mode(master_mode),
    .loopback(loopback), .frame_format(frame_format), .data_size(data_size),
    .idle_clock_polarity(idle_clock_polarity), .capture_phase_select(capture_phase_select),
    .prescale_divisor(prescale_divisor), .clock_rate_field(clock_rate_field),
    .interrupt_mask_register(interrupt_mask_register), .clear_timeout(clear_timeout),
    .clear_overrun(clear_overrun), .wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready),
    .rd_valid(rd_valid), .rd_data(rd_data), .rd_ready(rd_ready), .raw_interrupt_status(raw_interrupt_status),
    .masked_interrupt_status(masked_interrupt_status), .irq(irq), .busy(busy),
    .serial_bit_clock_in(1'b0), .serial_bit_clock_out(sclk), .serial_bit_clock_oe(sclk_oe),
    .frame_select_line_in(1'b1), .frame_select_line_out(fss), .frame_select_line_oe(fss_oe),
    .serial_in_line(miso), .serial_out_line(mosi), .serial_out_oe(mosi_oe));
  sspc_peer peer (.sclk(sclk), .fss(fss), .mosi(mosi), .miso(miso), .cpol(idle_clock_polarity),
    .cpha(capture_phase_select), .reply(peer_reply), .got(peer_got));

  // system clock, 100 ns period
  always #50 clock = ~clock;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // n consecutive words from w, entered at a rising edge
  task automatic push(input logic [15:0] w, input int n);
    for (int i = 0; i < n; i++) begin
      wr_valid <= 1'b1;
      wr_data <= w + 16'(i);
      @(posedge clock);
    end
    wr_valid <= 1'b0;
  endtask

  // bounded wait for the sequencer and buffer to empty
  task automatic wait_idle();
    int t;
    t = 0;
    @(negedge clock);
    while (busy !== 1'b0 && t < 3000) begin
      @(negedge clock);
      t++;
    end
    check(16'(t < 3000), 16'h0001);
    @(posedge clock);
  endtask

  // bounded wait for a received word, compare, take it
  task automatic pop(input logic [15:0] exp);
    int t;
    t = 0;
    @(negedge clock);
    while (rd_valid !== 1'b1 && t < 3000) begin
      @(negedge clock);
      t++;
    end
    check(rd_valid, 1'b1);
    check(rd_data, exp);
    @(posedge clock);
    rd_ready <= 1'b1;
    @(posedge clock);
    rd_ready <= 1'b0;
  endtask

  task automatic t_reset();
    check(wr_ready, 1'b1);
    check(rd_valid, 1'b0);
    check(raw_interrupt_status, 4'h1);
    check(irq, 1'b0);
    check(fss, 1'b1);
    check(sclk, 1'b0);
    check(sclk_oe, 1'b1);
  endtask

  // all four clock modes against the peer
  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      idle_clock_polarity <= m[1];
      capture_phase_select <= m[0];
      peer_reply <= 16'h00C3 ^ 16'(m);
      repeat (3) @(posedge clock);
      check(sclk, m[1]);
      push(16'h00A5 + 16'(m), 1);
      wait_idle();
      check(peer_got, 16'h00A5 + 16'(m));
      check(fss, 1'b1);
      pop(16'h00C3 ^ 16'(m));
    end
  endtask

  // half period from both dividers: 4/2 * (2+1)
  task automatic t_rate();
    int t;
    prescale_divisor <= 8'h04;
    clock_rate_field <= 8'h02;
    idle_clock_polarity <= 1'b0;
    capture_phase_select <= 1'b0;
    @(posedge clock);
    push(16'h005A, 1);
    t = 0;
    while (sclk !== 1'b1 && t < 200) begin
      @(negedge clock);
      t++;
    end
    t = 0;
    while (sclk === 1'b1 && t < 200) begin
      @(negedge clock);
      t++;
    end
    check(16'(t), 16'h0006);
    wait_idle();
    pop(16'h00C0);
  endtask

  // shortest and longest frames looped back
  task automatic t_size();
    loopback <= 1'b1;
    prescale_divisor <= 8'h02;
    clock_rate_field <= 8'h00;
    data_size <= 4'h3;
    @(posedge clock);
    push(16'h00F6, 1);
    wait_idle();
    pop(16'h0006);
    data_size <= 4'hF;
    @(posedge clock);
    push(16'hB38D, 1);
    wait_idle();
    pop(16'hB38D);
  endtask

  // frame pulse of one period, data looped back
  task automatic t_pulse();
    int t;
    frame_format <= 2'h1;
    data_size <= 4'h7;
    clock_rate_field <= 8'h01;
    @(posedge clock);
    push(16'h0096, 1);
    t = 0;
    repeat (20) begin
      @(negedge clock);
      if (fss === 1'b1) t++;
    end
    check(16'(t), 16'h0004);
    wait_idle();
    pop(16'h0096);
  endtask

  // command format: looped data after the command reads zero
  task automatic t_cmd();
    frame_format <= 2'h2;
    data_size <= 4'h7;
    @(posedge clock);
    push(16'h00FF, 1);
    wait_idle();
    pop(16'h0000);
  endtask

  // full buffers, overrun, masking and timeout
  task automatic t_fill();
    frame_format <= 2'h0;
    data_size <= 4'hF;
    enable <= 1'b0;
    @(posedge clock);
    push(16'h1000, 8);
    @(negedge clock);
    check(wr_ready, 1'b0);
    check(raw_interrupt_status[0], 1'b0);
    @(posedge clock);
    enable <= 1'b1;
    wait_idle();
    push(16'h2000, 3);
    wait_idle();
    check(raw_interrupt_status[3], 1'b1);
    check(raw_interrupt_status[1], 1'b1);
    interrupt_mask_register <= 4'h8;
    @(negedge clock);
    check(masked_interrupt_status, 4'h8);
    check(irq, 1'b1);
    @(posedge clock);
    interrupt_mask_register <= 4'h0;
    repeat (40) @(negedge clock);
    check(irq, 1'b0);
    check(raw_interrupt_status[2], 1'b1);
    for (int i = 0; i < 8; i++) pop(16'h1000 + 16'(i));
    for (int i = 0; i < 2; i++) pop(16'h2000 + 16'(i));
    @(posedge clock);
    clear_timeout <= 1'b1;
    clear_overrun <= 1'b1;
    @(posedge clock);
    clear_timeout <= 1'b0;
    clear_overrun <= 1'b0;
    @(negedge clock);
    check(raw_interrupt_status[3:2], 2'h0);
  endtask

  // reset, then the scenarios in turn
  initial begin
    clock = 1'b0;
    rstn = 1'b0;
    enable = 1'b1;
    master_mode = 1'b1;
    loopback = 1'b0;
    frame_format = 2'h0;
    data_size = 4'h7;
    idle_clock_polarity = 1'b0;
    capture_phase_select = 1'b0;
    prescale_divisor = 8'h02;
    clock_rate_field = 8'h00;
    interrupt_mask_register = 4'h0;
    clear_timeout = 1'b0;
    clear_overrun = 1'b0;
    wr_valid = 1'b0;
    wr_data = 16'h0000;
    rd_ready = 1'b0;
    peer_reply = 16'h0000;
    err_total = 0;
    comparisons = 0;
    repeat (3) @(posedge clock);
    @(negedge clock);
    t_reset();
    @(posedge clock);
    rstn <= 1'b1;
    t_modes();
    t_rate();
    t_size();
    t_pulse();
    t_cmd();
    t_fill();
    print_verdict();
  end

  // watchdog against a hang
  initial begin
    repeat (50000) @(posedge clock);
    err_total++;
    print_verdict();
  end
endmodule

// *** tb/sspc_peer.sv ***
`timescale 1ns/1ps
module sspc_peer (
  // link pins
  input wire logic sclk,
  input wire logic fss,
  input wire logic mosi,
  output logic miso,
  // mode and words
  input wire logic cpol,
  input wire logic cpha,
  input wire logic [15:0] reply,
  output logic [15:0] got
);
  logic [15:0] sh;
  initial begin
    miso = 1'b0;
    got = 16'h0000;
    sh = 16'h0000;
  end
  // select low loads an eight bit reply, msb first
  always @(negedge fss) begin
    sh = reply << 8;
    got = 16'h0000;
    miso = sh[15];
  end
  // capture on the phase edge, next bit on the other
  always @(sclk) begin
    if (!fss && ((sclk != cpol) != cpha)) begin
      got = {got[14:0], mosi};
    end else if (!fss && cpha) begin
      miso = sh[15];
      sh = sh << 1;
    end else if (!fss) begin
      sh = sh << 1;
      miso = sh[15];
    end
  end
  // released line shows the inverse of the last bit
  always @(posedge fss) miso = ~miso;
endmodule
